// ==== wdt_top.sv ====
/*
   Non-windowed watchdog timer: APB register slave on the bus clock, feed
   sequence checker, mode flags, and crossings to the counting-clock core.
   Assumes a system reset controller that pulses rst_n on chip_reset_req,
   and por_n low only for power-on or brown-out reset.
*/
// Overview of operation
// - bus clock serves register access only; counting runs on counting clock.
// - mode and constant updates act three counting clocks after crossing.
// - count is locked on counting clock, then passed to the bus side.
// - mode register at 0x000, read/write, resets to zero.
// - timeout constant at 0x004, read/write, resets to 0xFF.
// - writing 0xAA then 0x55 to 0x008 reloads the counter.
// - value register at 0x00C, read-only, reads 0xFF after reset.
// - mode writes act on counting and chip reset only after a completed feed.
// - bit 0 enables running, set only by software.
// - enable locks the counting clock source selection.
// - bit 1 makes timeout reset the chip, set only by software.
// - enable bits clear only on reset or timeout action (underflow or broken feed).
// - bit 2 timeout flag, software clears, of resets only power-on reset clears.
// - bit 3 interrupt flag, read-only, cleared by any reset.
// - interrupt request stays asserted while interrupt flag is set.
// - timeout fires whenever running with clock, also in sleep.
// - enable low means no running, regardless of reset enable.
// - interrupt mode underflow sets interrupt flag, no chip reset.
// - reset mode underflow resets chip; reset clears interrupt flag.
// - divide counting clock by four, decrement 24-bit counter per tick.
// - constants below 0xFF are replaced by 0xFF.
// - enable alone does not start; feed errors ignored until first feed.
// - after 0xAA, any other access triggers immediate timeout action.
`timescale 1ns/100ps
`default_nettype none
`include "wdt_regs.svh"

module wdt_top (
   input wire logic mclk,
   input wire logic rst_n,
   input wire logic por_n,
   input wire logic counting_clock,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [`WDT_ADDR_W-1:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   output logic wdt_irq,
   output logic chip_reset_req,
   output logic clk_src_lock
);

   function automatic logic hit(input logic [`WDT_ADDR_W-1:0] a,
                                input logic [`WDT_ADDR_W-1:0] off);
      hit = (a == off);
   endfunction : hit

   logic [1:0] rst_pipe_reg;
   logic [1:0] por_pipe_reg;
   logic brst_n;
   logic bpor_n;

   logic acc;
   logic wr;
   logic rd;
   logic feed_wr;
   logic mapped;

   logic run_enable_bit_reg;
   logic reset_enable_bit_reg;
   logic timeout_flag_reg;
   logic interrupt_flag_reg;
   logic eff_rst_reg;
   logic started_reg;
   wdt_pkg::count_t timeout_constant_reg;
   wdt_pkg::count_t counter_value_reg;
   wdt_pkg::feed_state_t feed_state_reg;

   logic feed_evt;
   logic abort_evt;
   wdt_pkg::load_cmd_t cmd_next;
   wdt_pkg::load_cmd_t pend_cmd_reg;
   wdt_pkg::load_cmd_t load_cmd_reg;
   logic pend_reg;
   logic load_req_tgl_reg;
   logic load_ack_tgl;
   logic load_ack_s;
   logic busy;

   logic timeout_tgl;
   logic timeout_s;
   logic timeout_d_reg;
   logic timeout_evt;
   wdt_pkg::count_t snap;
   logic snap_req_tgl;
   logic snap_req_s;
   logic snap_ack_reg;

   always_ff @(posedge mclk or negedge rst_n)
   begin
      if (!rst_n)
         rst_pipe_reg <= 2'h0;
      else
         rst_pipe_reg <= {rst_pipe_reg[0], 1'b1};
   end
   assign brst_n = rst_pipe_reg[1];

   always_ff @(posedge mclk or negedge por_n)
   begin
      if (!por_n)
         por_pipe_reg <= 2'h0;
      else
         por_pipe_reg <= {por_pipe_reg[0], 1'b1};
   end
   assign bpor_n = por_pipe_reg[1];

   // access phase lasts two cycles so read data can come from a flop
   assign acc = psel & penable & ~pready;
   assign wr = acc & pwrite;
   assign rd = acc & ~pwrite;
   assign feed_wr = wr & hit(paddr, `WDT_OFF_FEED);
   assign mapped = hit(paddr, `WDT_OFF_MODE) | hit(paddr, `WDT_OFF_TC) |
                   hit(paddr, `WDT_OFF_FEED) | hit(paddr, `WDT_OFF_VALUE);

   always_ff @(posedge mclk or negedge brst_n)
   begin
      if (!brst_n)
      begin
         pready <= 1'b0;
         pslverr <= 1'b0;
         prdata <= 32'h00000000;
      end
      else
      begin
         pready <= acc;
         pslverr <= acc & ~mapped;
         prdata <= 32'h00000000;
         if (rd)
         begin
            if (hit(paddr, `WDT_OFF_MODE))
               prdata <= {28'h0000000, interrupt_flag_reg, timeout_flag_reg,
                          reset_enable_bit_reg, run_enable_bit_reg};
            else if (hit(paddr, `WDT_OFF_TC))
               prdata <= {8'h00, timeout_constant_reg};
            else if (hit(paddr, `WDT_OFF_VALUE))
               prdata <= {8'h00, counter_value_reg};
         end
      end
   end

   always_ff @(posedge mclk or negedge brst_n)
   begin
      if (!brst_n)
         timeout_constant_reg <= `WDT_TC_RESET;
      else if (wr && hit(paddr, `WDT_OFF_TC))
      begin
         if (pwdata[`WDT_CNT_W-1:0] < `WDT_TC_MIN)
            timeout_constant_reg <= `WDT_TC_MIN;
         else
            timeout_constant_reg <= pwdata[`WDT_CNT_W-1:0];
      end
   end

   // set-only enables; underflow clears them, writes never do
   always_ff @(posedge mclk or negedge brst_n)
   begin
      if (!brst_n)
      begin
         run_enable_bit_reg <= 1'b0;
         reset_enable_bit_reg <= 1'b0;
      end
      else if (timeout_evt)
      begin
         run_enable_bit_reg <= 1'b0;
         reset_enable_bit_reg <= 1'b0;
      end
      else if (wr && hit(paddr, `WDT_OFF_MODE))
      begin
         run_enable_bit_reg <= run_enable_bit_reg | pwdata[`WDT_BIT_EN];
         reset_enable_bit_reg <= reset_enable_bit_reg | pwdata[`WDT_BIT_RST_EN];
      end
   end

   // survives a watchdog reset; set wins over a clearing write
   always_ff @(posedge mclk or negedge bpor_n)
   begin
      if (!bpor_n)
         timeout_flag_reg <= 1'b0;
      else if (timeout_evt)
         timeout_flag_reg <= 1'b1;
      else if (wr && hit(paddr, `WDT_OFF_MODE) && !pwdata[`WDT_BIT_TOF])
         timeout_flag_reg <= 1'b0;
   end

   always_ff @(posedge mclk or negedge brst_n)
   begin
      if (!brst_n)
         interrupt_flag_reg <= 1'b0;
      else if (timeout_evt)
         interrupt_flag_reg <= 1'b1;
   end

   always_ff @(posedge mclk or negedge brst_n)
   begin
      if (!brst_n)
      begin
         wdt_irq <= 1'b0;
         chip_reset_req <= 1'b0;
         clk_src_lock <= 1'b0;
      end
      else
      begin
         wdt_irq <= interrupt_flag_reg;
         chip_reset_req <= timeout_evt & eff_rst_reg;
         clk_src_lock <= run_enable_bit_reg;
      end
   end

   always_ff @(posedge mclk or negedge brst_n)
   begin
      if (!brst_n)
         feed_state_reg <= wdt_pkg::FEED_IDLE;
      else
      begin
         case (feed_state_reg)
            wdt_pkg::FEED_IDLE:
               if (feed_wr && pwdata[7:0] == `WDT_FEED_FIRST)
                  feed_state_reg <= wdt_pkg::FEED_ARMED;
            wdt_pkg::FEED_ARMED:
               if (acc)
                  feed_state_reg <= wdt_pkg::FEED_IDLE;
            default:
               feed_state_reg <= wdt_pkg::FEED_IDLE;
         endcase
      end
   end

   assign feed_evt = (feed_state_reg == wdt_pkg::FEED_ARMED) && feed_wr &&
                     pwdata[7:0] == `WDT_FEED_SECOND;
   // errors before the first good feed are ignored
   assign abort_evt = (feed_state_reg == wdt_pkg::FEED_ARMED) && acc &&
                      !feed_evt && started_reg;

   // mode is sampled for counting and chip reset only at a feed, so plain writes change neither yet
   always_ff @(posedge mclk or negedge brst_n)
   begin
      if (!brst_n)
      begin
         eff_rst_reg <= 1'b0;
         started_reg <= 1'b0;
      end
      else if (timeout_evt)
         started_reg <= 1'b0;
      else if (feed_evt)
      begin
         eff_rst_reg <= reset_enable_bit_reg;
         started_reg <= run_enable_bit_reg;
      end
   end

   always_comb
   begin
      cmd_next.abort = abort_evt;
      cmd_next.run_en = feed_evt ? run_enable_bit_reg : started_reg;
      cmd_next.reload = timeout_constant_reg;
   end

   // latest command waits while the previous handshake is in flight
   assign busy = load_req_tgl_reg ^ load_ack_s;

   always_ff @(posedge mclk or negedge brst_n)
   begin
      if (!brst_n)
      begin
         pend_reg <= 1'b0;
         pend_cmd_reg <= '0;
         load_cmd_reg <= '0;
         load_req_tgl_reg <= 1'b0;
      end
      else
      begin
         if (feed_evt || abort_evt)
         begin
            pend_cmd_reg <= cmd_next;
            pend_reg <= 1'b1;
         end
         else if (pend_reg && !busy)
         begin
            load_cmd_reg <= pend_cmd_reg;
            load_req_tgl_reg <= ~load_req_tgl_reg;
            pend_reg <= 1'b0;
         end
      end
   end

   bit_sync #(.W(3)) u_sync (
      .clk(mclk),
      .rst_n(brst_n),
      .d({load_ack_tgl, timeout_tgl, snap_req_tgl}),
      .q({load_ack_s, timeout_s, snap_req_s})
   );

   assign timeout_evt = timeout_s ^ timeout_d_reg;

   always_ff @(posedge mclk or negedge brst_n)
   begin
      if (!brst_n)
      begin
         timeout_d_reg <= 1'b0;
         snap_ack_reg <= 1'b0;
         counter_value_reg <= `WDT_VALUE_RESET;
      end
      else
      begin
         timeout_d_reg <= timeout_s;
         snap_ack_reg <= snap_req_s;
         if (snap_req_s != snap_ack_reg)
            counter_value_reg <= snap;
      end
   end

   wdt_count_core u_core (
      .counting_clock(counting_clock),
      .rst_n(rst_n),
      .load_cmd(load_cmd_reg),
      .load_req_tgl(load_req_tgl_reg),
      .load_ack_tgl(load_ack_tgl),
      .timeout_tgl(timeout_tgl),
      .snap(snap),
      .snap_req_tgl(snap_req_tgl),
      .snap_ack_tgl(snap_ack_reg)
   );

endmodule : wdt_top

`default_nettype wire

// ==== wdt_regs.svh ====
/*
   Register offsets, field positions, reset values and counts of the watchdog.
   Assumes it is included by bare name wherever these macros are used.
*/
`ifndef WDT_REGS_SVH
`define WDT_REGS_SVH

`define WDT_ADDR_W 12
`define WDT_OFF_MODE 12'h000
`define WDT_OFF_TC 12'h004
`define WDT_OFF_FEED 12'h008
`define WDT_OFF_VALUE 12'h00C

`define WDT_BIT_EN 0
`define WDT_BIT_RST_EN 1
`define WDT_BIT_TOF 2
`define WDT_BIT_INT 3

`define WDT_CNT_W 24
`define WDT_TC_RESET 24'h0000FF
`define WDT_TC_MIN 24'h0000FF
`define WDT_VALUE_RESET 24'h0000FF

`define WDT_FEED_FIRST 8'hAA
`define WDT_FEED_SECOND 8'h55

`define WDT_PRESCALE_LAST 2'h3

`endif

// ==== wdt_pkg.sv ====
/*
   Types shared by the watchdog bus-side and counting-side logic.
   Assumes wdt_regs.svh for widths.
*/
`default_nettype none
`include "wdt_regs.svh"

package wdt_pkg;

   typedef logic [`WDT_CNT_W-1:0] count_t;

   typedef enum logic [1:0] {
      FEED_IDLE = 2'b01,
      FEED_ARMED = 2'b10
   } feed_state_t;

   // payload carried from bus clock to counting clock
   typedef struct packed {
      logic abort;
      logic run_en;
      count_t reload;
   } load_cmd_t;

endpackage : wdt_pkg

`default_nettype wire

// ==== bit_sync.sv ====
/*
   Two-flop synchroniser for a vector of independent level or toggle bits.
   Assumes each bit changes at most once per several destination clocks.
*/
`timescale 1ns/100ps
`default_nettype none

module bit_sync #(
   parameter int W = 1
) (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic [W-1:0] d,
   output logic [W-1:0] q
);

   logic [W-1:0] meta_reg;

   // meta_reg feeds only q
   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         meta_reg <= '0;
         q <= '0;
      end
      else
      begin
         meta_reg <= d;
         q <= meta_reg;
      end
   end

endmodule : bit_sync

`default_nettype wire

// ==== wdt_count_core.sv ====
/*
   Counting-clock side of the watchdog: prescaler, 24-bit down counter,
   load handshake receiver, timeout toggle and counter snapshot sender.
   Assumes load_cmd is held stable while load_req_tgl differs from load_ack_tgl.
*/
`timescale 1ns/100ps
`default_nettype none
`include "wdt_regs.svh"

module wdt_count_core (
   input wire logic counting_clock,
   input wire logic rst_n,
   input wire wdt_pkg::load_cmd_t load_cmd,
   input wire logic load_req_tgl,
   output logic load_ack_tgl,
   output logic timeout_tgl,
   output wdt_pkg::count_t snap,
   output logic snap_req_tgl,
   input wire logic snap_ack_tgl
);

   logic [1:0] rst_pipe_reg;
   logic crst_n;
   logic req_s;
   logic req_d_reg;
   logic snap_ack_s;
   logic load_now;
   logic run_reg;
   logic [1:0] presc_reg;
   wdt_pkg::count_t count_reg;

   always_ff @(posedge counting_clock or negedge rst_n)
   begin
      if (!rst_n)
         rst_pipe_reg <= 2'h0;
      else
         rst_pipe_reg <= {rst_pipe_reg[0], 1'b1};
   end
   assign crst_n = rst_pipe_reg[1];

   bit_sync #(.W(2)) u_sync (
      .clk(counting_clock),
      .rst_n(crst_n),
      .d({load_req_tgl, snap_ack_tgl}),
      .q({req_s, snap_ack_s})
   );

   // two sync flops plus this edge flop: new settings act on the third edge
   assign load_now = req_s ^ req_d_reg;

   always_ff @(posedge counting_clock or negedge crst_n)
   begin
      if (!crst_n)
      begin
         req_d_reg <= 1'b0;
         load_ack_tgl <= 1'b0;
      end
      else
      begin
         req_d_reg <= req_s;
         load_ack_tgl <= req_s;
      end
   end

   always_ff @(posedge counting_clock or negedge crst_n)
   begin
      if (!crst_n)
      begin
         run_reg <= 1'b0;
         presc_reg <= 2'h0;
         count_reg <= `WDT_VALUE_RESET;
         timeout_tgl <= 1'b0;
      end
      else if (load_now)
      begin
         presc_reg <= 2'h0;
         count_reg <= load_cmd.reload;
         if (load_cmd.abort && run_reg)
         begin
            timeout_tgl <= ~timeout_tgl;
            run_reg <= 1'b0;
         end
         else
            run_reg <= load_cmd.run_en;
      end
      else if (run_reg)
      begin
         presc_reg <= presc_reg + 2'h1;
         if (presc_reg == `WDT_PRESCALE_LAST)
         begin
            if (count_reg == '0)
            begin
               timeout_tgl <= ~timeout_tgl;
               run_reg <= 1'b0;
            end
            else
               count_reg <= count_reg - `WDT_CNT_W'(1);
         end
      end
   end

   // lock the count here, then hand it to the bus side
   always_ff @(posedge counting_clock or negedge crst_n)
   begin
      if (!crst_n)
      begin
         snap <= `WDT_VALUE_RESET;
         snap_req_tgl <= 1'b0;
      end
      else if (snap_req_tgl == snap_ack_s)
      begin
         snap <= count_reg;
         snap_req_tgl <= ~snap_req_tgl;
      end
   end

endmodule : wdt_count_core

`default_nettype wire

// ==== wdt_top_props.sv ====
/*
   Port checker for the watchdog top: bus answer timing, read fields, flags.
   Assumes it is bound onto wdt_top and sees only its ports.
*/
`timescale 1ns/100ps
`default_nettype none
`include "wdt_regs.svh"

module wdt_top_chk (
   input wire logic mclk,
   input wire logic rst_n,
   input wire logic por_n,
   input wire logic counting_clock,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [`WDT_ADDR_W-1:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [31:0] prdata,
   input wire logic pready,
   input wire logic pslverr,
   input wire logic wdt_irq,
   input wire logic chip_reset_req,
   input wire logic clk_src_lock
);
   default clocking cb @(posedge mclk);
   endclocking
   default disable iff (!rst_n);
   logic rd_ok;
   assign rd_ok = pready && !pwrite && !pslverr;

   a_ready_pulse: assert property (pready |=> !pready)
      else $error("ready held too long");
   a_ready_late: assert property (psel && penable && !pready |=> pready)
      else $error("ready not one cycle after access");
   a_bad_offset: assert property (pready |-> pslverr == (paddr > 12'h00C || paddr[1:0] != 2'h0))
      else $error("error flag wrong for offset");
   a_mode_upper: assert property (rd_ok && paddr == `WDT_OFF_MODE |-> prdata[31:4] == 28'h0)
      else $error("mode upper bits not zero");
   a_const_floor: assert property (rd_ok && paddr == `WDT_OFF_TC |-> prdata[23:0] >= 24'h0000FF)
      else $error("constant below floor");
   a_feed_zero: assert property (rd_ok && paddr == `WDT_OFF_FEED |-> prdata == 32'h0)
      else $error("feed read not zero");
   a_lock_mirror: assert property (rd_ok && paddr == `WDT_OFF_MODE |-> prdata[0] == clk_src_lock)
      else $error("lock differs from enable");
   a_irq_sticky: assert property (wdt_irq |=> wdt_irq)
      else $error("interrupt dropped without reset");
   a_reset_pulse: assert property (chip_reset_req |=> !chip_reset_req)
      else $error("reset request longer than a cycle");
   a_en_clear: assert property ($fell(clk_src_lock) |-> ##[0:4] wdt_irq)
      else $error("enable cleared without timeout");
   c_reset_req: cover property (chip_reset_req);
endmodule : wdt_top_chk

bind wdt_top wdt_top_chk chk_u (.mclk(mclk), .rst_n(rst_n), .por_n(por_n),
   .counting_clock(counting_clock), .psel(psel), .penable(penable), .pwrite(pwrite),
   .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
   .wdt_irq(wdt_irq), .chip_reset_req(chip_reset_req), .clk_src_lock(clk_src_lock));
`default_nettype wire

// ==== apb_host.sv ====
/*
   Host model: one bus transfer at a time, setup then access phase.
   Assumes a slave that answers within a few cycles.
*/
`timescale 1ns/100ps
`default_nettype none

module apb_host (
   input wire logic mclk,
   output logic psel,
   output logic penable,
   output logic pwrite,
   output logic [11:0] paddr,
   output logic [31:0] pwdata,
   input wire logic [31:0] prdata,
   input wire logic pready,
   input wire logic pslverr
);
   initial
   begin
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 12'h000;
      pwdata = 32'h0;
   end
   task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d,
                       output logic [31:0] r, output logic e);
      int n;
      n = 0;
      @(posedge mclk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge mclk);
      penable <= 1'b1;
      do
      begin
         @(posedge mclk);
         n++;
      end
      while (pready !== 1'b1 && n < 8);
      // a slave that never answers shows up as an error and unknown data
      r = (pready === 1'b1) ? prdata : 32'hXXXXXXXX;
      e = (pready === 1'b1) ? pslverr : 1'b1;
      psel <= 1'b0;
      penable <= 1'b0;
      // released lines flip so stale values never pass
      paddr <= ~a;
      pwdata <= ~d;
   endtask : xfer
endmodule : apb_host
`default_nettype wire

// ==== testbench.sv ====
/*
   Self-checking bench for wdt_top against an integer model.
   Assumes apb_host and the bound checker are compiled with it.
*/
`timescale 1ns/100ps
`default_nettype none

module testbench;
   logic mclk = 1'b0;
   logic counting_clock = 1'b0;
   logic rst_n = 1'b0;
   logic por_n = 1'b0;
   logic psel, penable, pwrite, pready, pslverr, wdt_irq, chip_reset_req, clk_src_lock, ev;
   logic [11:0] paddr;
   logic [31:0] pwdata, prdata, rv;
   int bad_count = 0;
   int checks_done = 0;
   int rst_seen = 0;
   int mode_m, tc_m, n, el, ex;
   time t0;
   always #20 mclk = ~mclk;
   // unrelated to the bus clock
   always #13 counting_clock = ~counting_clock;
   always @(posedge mclk) if (chip_reset_req === 1'b1) rst_seen++;

   wdt_top dut_u (.mclk(mclk), .rst_n(rst_n), .por_n(por_n), .counting_clock(counting_clock),
      .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
      .prdata(prdata), .pready(pready), .pslverr(pslverr), .wdt_irq(wdt_irq),
      .chip_reset_req(chip_reset_req), .clk_src_lock(clk_src_lock));
   apb_host host_u (.mclk(mclk), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr));

   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      checks_done++;
      if (seen !== exp)
      begin
         bad_count++;
         $display("Error at %0t: saw %h expected %h", $time, seen, exp);
      end
   endtask : chk
   task automatic wr(input logic [11:0] a, input logic [31:0] d);
      host_u.xfer(1'b1, a, d, rv, ev);
      chk({31'h0, ev}, 32'h0);
      // set-only enables, timeout flag cleared by a zero
      if (a == 12'h000)
         mode_m = (mode_m | (d & 3)) & (d[2] ? 15 : 11);
      if (a == 12'h004)
         tc_m = (d[23:0] < 24'h0000FF) ? 255 : d[23:0];
   endtask : wr
   task automatic rdm;
      host_u.xfer(1'b0, 12'h000, 32'h0, rv, ev);
      chk(rv, mode_m);
   endtask : rdm
   task automatic feed;
      wr(12'h008, 32'h000000AA);
      wr(12'h008, 32'h00000055);
   endtask : feed
   task automatic reset(input logic keep);
      @(posedge mclk);
      rst_n <= 1'b0;
      por_n <= keep;
      repeat (2) @(posedge mclk);
      rst_n <= 1'b1;
      por_n <= 1'b1;
      repeat (4) @(posedge mclk);
      mode_m = keep ? (mode_m & 4) : 0;
      tc_m = 255;
   endtask : reset
   task automatic end_sim;
      $display("Checks %0d, mismatches %0d", checks_done, bad_count);
      if (bad_count == 0 && checks_done > 0)
         $display("Test passed");
      else
         $display("Test failed");
      $finish;
   endtask : end_sim

   initial
   begin
      #(40 * 8000);
      bad_count++;
      end_sim();
   end

   initial
   begin
      n = $urandom(32'hC2D0E78A);
      tc_m = 255;
      reset(1'b0);
      rdm();
      host_u.xfer(1'b0, 12'h004, 32'h0, rv, ev);
      chk(rv, tc_m);
      host_u.xfer(1'b0, 12'h00C, 32'h0, rv, ev);
      chk(rv, 32'h000000FF);
      host_u.xfer(1'b0, 12'h010, 32'h0, rv, ev);
      chk({31'h0, ev}, 32'h1);
      host_u.xfer(1'b0, 12'h008, 32'h0, rv, ev);
      chk(rv, 32'h0);
      wr(12'h004, 32'h00000010);
      host_u.xfer(1'b0, 12'h004, 32'h0, rv, ev);
      chk(rv, tc_m);
      wr(12'h000, 32'h1);
      rdm();
      chk({31'h0, clk_src_lock}, 32'h1);
      wr(12'h000, 32'h0);
      rdm();
      // broken sequence before any feed must be ignored
      wr(12'h008, 32'h000000AA);
      host_u.xfer(1'b0, 12'h004, 32'h0, rv, ev);
      repeat (60) @(posedge mclk);
      chk({31'h0, wdt_irq}, 32'h0);
      // enable alone must leave the count parked at its reset value
      host_u.xfer(1'b0, 12'h00C, 32'h0, rv, ev);
      chk(rv, 32'h000000FF);
      feed();
      t0 = $time;
      repeat (100) @(posedge mclk);
      host_u.xfer(1'b0, 12'h00C, 32'h0, rv, ev);
      chk({31'h0, rv <= tc_m && rv + 64 >= tc_m}, 32'h1);
      n = 0;
      while (wdt_irq !== 1'b1 && n < 2000)
      begin
         @(posedge mclk);
         n++;
      end
      el = ($time - t0) / 40;
      ex = (tc_m + 1) * 4 * 26 / 40;
      chk({31'h0, el >= ex - 10 && el <= ex + 30}, 32'h1);
      mode_m = (mode_m & 12) | 12;
      rdm();
      chk(rst_seen, 0);
      wr(12'h000, 32'h0);
      rdm();
      chk({31'h0, wdt_irq}, 32'h1);
      reset(1'b1);
      rdm();
      wr(12'h004, 32'h100 + $urandom % 64);
      host_u.xfer(1'b0, 12'h004, 32'h0, rv, ev);
      chk(rv, tc_m);
      wr(12'h000, 32'h3);
      feed();
      repeat (40) @(posedge mclk);
      wr(12'h008, 32'h000000AA);
      host_u.xfer(1'b0, 12'h00C, 32'h0, rv, ev);
      n = 0;
      while (rst_seen == 0 && n < 80)
      begin
         @(posedge mclk);
         n++;
      end
      chk(rst_seen, 1);
      mode_m = (mode_m & 12) | 12;
      reset(1'b1);
      rdm();
      reset(1'b0);
      rdm();
      end_sim();
   end
endmodule : testbench
`default_nettype wire
